// ---- design/fieldbus_defines.svh ----
// Constants for the fieldbus process-data monitor: telegram codes, lengths and timing.
// Assumes a 10 MHz reference clock; included by the package users by bare name.
`ifndef FIELDBUS_DEFINES_SVH
`define FIELDBUS_DEFINES_SVH

`define TEL_NONE        10'h000
`define TEL_BASIC       10'h001
`define TEL_EXTENDED    10'h014
`define TEL_SYSTEM      10'h160
`define TEL_FREE        10'h3e7

`define LEN_BASIC_RX    4'h2
`define LEN_BASIC_TX    4'h2
`define LEN_EXT_RX      4'h2
`define LEN_EXT_TX      4'h6
`define LEN_SYS_RX      4'h6
`define LEN_SYS_TX      4'h6
`define LEN_FREE        4'ha
`define MAX_WORDS       10

`define READY_BIT       9
`define CLK_PERIOD_NS   100
`define TICK_TIME_NS    1000000
`define TICK_CYCLES     (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define FLASH_HALF_MS   16'h03e8

`endif

// ---- design/fieldbus_pkg.sv ----
// Types shared by the fieldbus process-data monitor and its bench.
// Holds no constants; those live in the defines header.
package fieldbus_pkg;

   typedef struct packed {
      logic [3:0]  index;
      logic        last;
      logic [15:0] data;
   } telegram_word_type;

   typedef struct packed {
      logic [15:0] statusBits;
      logic [15:0] speedActualA;
      logic [15:0] speedActualFiltered;
      logic [15:0] armatureCurrentFiltered;
      logic [15:0] torqueActualFiltered;
      logic [15:0] powerActualFiltered;
      logic [15:0] processSignalWord;
      logic [15:0] alarmCode;
      logic [15:0] faultCode;
   } actual_values_type;

   // Send-word sources and receive-word destinations.
   typedef enum logic [3:0] {
      SRC_NONE, SRC_STATUS, SRC_SPEED, SRC_SPEED_FILT, SRC_CURRENT,
      SRC_TORQUE, SRC_POWER, SRC_PROCESS, SRC_ALARM, SRC_FAULT
   } tx_source_type;

   typedef enum logic [3:0] {
      DST_NONE, DST_CONTROL, DST_SPEED, DST_SYS3, DST_SYS4, DST_SYS5, DST_SYS6
   } rx_dest_type;

   typedef enum logic [1:0] {
      SEND_IDLE = 2'b01,
      SEND_BUSY = 2'b10
   } send_state_type;

endpackage

// ---- design/fieldbus_process_data_monitor.sv ----
// Slave-side process-data handler: word mapping, status indicator and telegram-loss supervision.
// Assumes all inputs are synchronous to ref_clk and that the master polls send words with txRequest.
//
// Summary of operation
// - Indicator dark before any cyclic exchange.
// - Steady green while exchange fully runs.
// - Green flashes 0.5 Hz when exchange partial.
// - Steady red once running exchange interrupted.
// - Monitor timeout sets loss flag and alarm.
// - Further delay raises fault, default quick stop.
// - Fault reaction configurable to no stop.
// - Telegram select decides exchanged words.
// - Receive control/setpoints, send status/actuals.
// - Codes 1, 20, 352 load fixed mappings.
// - Code 999 keeps mapping, freely editable.
// - Telegram select resets to 999.
// - Leaving 999 applies and locks mapping.
// - Codes 20/352 leave some words assignable.
// - Returning to 999 keeps mapping, unlocks.
// - Extended select under 999 locks, allows appending.
// - Telegram lengths per code, up to ten.
// - Receive word 2 is 16-bit speed setpoint.
`timescale 1ns/1ps
`include "fieldbus_defines.svh"

module fieldbus_process_data_monitor
   import fieldbus_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              rxValid,
   input  wire telegram_word_type rxWord,
   input  wire actual_values_type actualValues,
   input  wire logic              selWrite,
   input  wire logic              selExtended,
   input  wire logic [9:0]        selValue,
   input  wire logic              cfgWrite,
   input  wire logic              cfgRxSide,
   input  wire logic [3:0]        cfgIndex,
   input  wire logic [3:0]        cfgCode,
   input  wire logic [15:0]       lossMonitorTime,
   input  wire logic [15:0]       lossFaultDelay,
   input  wire logic              quickStopEnable,
   input  wire logic              faultAck,
   input  wire logic              txRequest,
   input  wire logic              txReady,
   output logic                   txValid,
   output telegram_word_type      txWord,
   output logic [15:0]            controlWordOne,
   output logic [15:0]            speedSetpointA,
   output logic [3:0][15:0]       systemSetpoint,
   output logic [9:0]             telegramSelect,
   output logic [9:0]             telegramSelectExtended,
   output logic                   telegramLossFlag,
   output logic                   telegramLossAlarm,
   output logic                   telegramLossFault,
   output logic                   quickStopReaction,
   output logic                   statusLedGreen,
   output logic                   statusLedRed
);

   function automatic logic [3:0] rxLen(input logic [9:0] code);
      case (code)
         `TEL_BASIC:    rxLen = `LEN_BASIC_RX;
         `TEL_EXTENDED: rxLen = `LEN_EXT_RX;
         `TEL_SYSTEM:   rxLen = `LEN_SYS_RX;
         `TEL_FREE:     rxLen = `LEN_FREE;
         default:       rxLen = 4'h0;
      endcase
   endfunction

   function automatic logic [3:0] txLen(input logic [9:0] code);
      case (code)
         `TEL_BASIC:    txLen = `LEN_BASIC_TX;
         `TEL_EXTENDED: txLen = `LEN_EXT_TX;
         `TEL_SYSTEM:   txLen = `LEN_SYS_TX;
         `TEL_FREE:     txLen = `LEN_FREE;
         default:       txLen = 4'h0;
      endcase
   endfunction

   function automatic tx_source_type defaultTx(input logic [9:0] code, input int idx);
      defaultTx = SRC_NONE;
      if (idx == 0) begin
         defaultTx = SRC_STATUS;
      end else if (code == `TEL_BASIC) begin
         if (idx == 1) defaultTx = SRC_SPEED;
      end else if (code == `TEL_EXTENDED) begin
         case (idx)
            1:       defaultTx = SRC_SPEED_FILT;
            2:       defaultTx = SRC_CURRENT;
            3:       defaultTx = SRC_TORQUE;
            4:       defaultTx = SRC_POWER;
            5:       defaultTx = SRC_PROCESS;
            default: defaultTx = SRC_NONE;
         endcase
      end else if (code == `TEL_SYSTEM) begin
         case (idx)
            1:       defaultTx = SRC_SPEED_FILT;
            2:       defaultTx = SRC_CURRENT;
            3:       defaultTx = SRC_TORQUE;
            4:       defaultTx = SRC_ALARM;
            5:       defaultTx = SRC_FAULT;
            default: defaultTx = SRC_NONE;
         endcase
      end
   endfunction

   function automatic rx_dest_type defaultRx(input logic [9:0] code, input int idx);
      defaultRx = DST_NONE;
      if (idx == 0) begin
         defaultRx = DST_CONTROL;
      end else if (idx == 1) begin
         defaultRx = DST_SPEED;
      end else if (code == `TEL_SYSTEM && idx < 6) begin
         defaultRx = rx_dest_type'(4'(DST_SYS3) + 4'(idx - 2));
      end
   endfunction

   // Telegram in force: the main select, or the extended one under the free telegram.
   logic [9:0]          effCode;
   logic [9:0]          prevEff;
   logic                loadMap;
   logic [`MAX_WORDS-1:0] txLock;
   logic [`MAX_WORDS-1:0] rxLock;
   tx_source_type       txMap [`MAX_WORDS];
   rx_dest_type         rxMap [`MAX_WORDS];
   logic                isFree;
   logic                openSpare;

   assign isFree    = telegramSelect == `TEL_FREE;
   assign effCode   = isFree ? telegramSelectExtended : telegramSelect;
   assign openSpare = effCode == `TEL_EXTENDED || effCode == `TEL_SYSTEM;
   assign loadMap   = effCode != prevEff && rxLen(effCode) != 4'h0 && effCode != `TEL_FREE;

   always_comb begin
      for (int i = 0; i < `MAX_WORDS; i++) begin
         txLock[i] = 4'(i) < txLen(effCode) && effCode != `TEL_FREE && !(openSpare && i == 5);
         rxLock[i] = 4'(i) < rxLen(effCode) && effCode != `TEL_FREE && !(openSpare && i >= 2 && i <= 5);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         telegramSelect         <= `TEL_FREE;
         telegramSelectExtended <= `TEL_NONE;
         prevEff                <= `TEL_NONE;
      end else begin
         prevEff <= effCode;
         if (selWrite && !selExtended) telegramSelect <= selValue;
         if (selWrite && selExtended) telegramSelectExtended <= selValue;
      end
   end

   // Mapping table: fixed codes overwrite their words, the rest is kept (appendable).
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `MAX_WORDS; i++) begin
            txMap[i] <= defaultTx(`TEL_BASIC, i);
            rxMap[i] <= defaultRx(`TEL_BASIC, i);
         end
      end else if (loadMap) begin
         for (int i = 0; i < `MAX_WORDS; i++) begin
            if (4'(i) < txLen(effCode)) txMap[i] <= defaultTx(effCode, i);
            if (4'(i) < rxLen(effCode)) rxMap[i] <= defaultRx(effCode, i);
         end
      end else if (cfgWrite && cfgIndex < `LEN_FREE) begin
         if (cfgRxSide && !rxLock[cfgIndex]) rxMap[cfgIndex] <= rx_dest_type'(cfgCode);
         if (!cfgRxSide && !txLock[cfgIndex]) txMap[cfgIndex] <= tx_source_type'(cfgCode);
      end
   end

   // Receive side: words are staged and applied when a telegram closes within its expected length, short ones included.
   logic [15:0] stage [`MAX_WORDS];
   logic [3:0]  rxCount;
   logic [3:0]  expRx;
   logic [3:0]  gotCount;
   logic        frameOk;
   logic        frameFull;

   assign expRx     = rxLen(telegramSelect);
   assign gotCount  = rxCount + 4'h1;
   assign frameOk   = rxValid && rxWord.last && expRx != 4'h0 && gotCount <= expRx;
   assign frameFull = isFree ? gotCount >= 4'h2 : gotCount == expRx;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rxCount <= 4'h0;
      end else if (rxValid) begin
         rxCount <= rxWord.last ? 4'h0 : (rxCount == `LEN_FREE ? rxCount : gotCount);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rxValid && rxWord.index < `LEN_FREE) begin
         stage[rxWord.index] <= rxWord.data;
      end
   end

   // The closing word bypasses the stage, which only takes it at the same edge.
   logic [15:0] frameData [`MAX_WORDS];

   always_comb begin
      for (int i = 0; i < `MAX_WORDS; i++) begin
         frameData[i] = (4'(i) == rxWord.index) ? rxWord.data : stage[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         controlWordOne <= 16'h0000;
         speedSetpointA <= 16'h0000;
         systemSetpoint <= '0;
      end else if (frameOk) begin
         for (int i = 0; i < `MAX_WORDS; i++) begin
            if (4'(i) < gotCount) begin
               case (rxMap[i])
                  DST_CONTROL: controlWordOne <= frameData[i];
                  DST_SPEED:   speedSetpointA <= frameData[i];
                  DST_SYS3:    systemSetpoint[0] <= frameData[i];
                  DST_SYS4:    systemSetpoint[1] <= frameData[i];
                  DST_SYS5:    systemSetpoint[2] <= frameData[i];
                  DST_SYS6:    systemSetpoint[3] <= frameData[i];
                  default:     ;
               endcase
            end
         end
      end
   end

   // Prescaled millisecond tick shared by the flash and both supervision timers.
   logic [13:0] preCnt;
   logic        tick;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         preCnt <= 14'h0000;
         tick   <= 1'b0;
      end else begin
         tick   <= preCnt == 14'(TICK_CYCLES - 1);
         preCnt <= preCnt == 14'(TICK_CYCLES - 1) ? 14'h0000 : preCnt + 14'h0001;
      end
   end

   logic        exchanged;
   logic        lastFull;
   logic [15:0] monCnt;
   logic [15:0] delayCnt;
   logic        ackHold;
   logic        faultSet;

   assign faultSet = telegramLossFlag && tick && delayCnt >= lossFaultDelay && !ackHold;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         exchanged <= 1'b0;
         lastFull  <= 1'b0;
      end else if (frameOk) begin
         exchanged <= 1'b1;
         lastFull  <= frameFull;
      end
   end

   // A zero monitoring time switches supervision off.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         monCnt           <= 16'h0000;
         delayCnt         <= 16'h0000;
         telegramLossFlag <= 1'b0;
      end else if (frameOk) begin
         monCnt           <= 16'h0000;
         delayCnt         <= 16'h0000;
         telegramLossFlag <= 1'b0;
      end else if (tick && exchanged && lossMonitorTime != 16'h0000) begin
         if (!telegramLossFlag) begin
            monCnt <= monCnt + 16'h0001;
            if (monCnt + 16'h0001 >= lossMonitorTime) telegramLossFlag <= 1'b1;
         end else if (delayCnt != 16'hffff) begin
            delayCnt <= delayCnt + 16'h0001;
         end
      end
   end

   // A set in the same cycle as an acknowledge wins; the fault then needs a second acknowledge.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         telegramLossFault <= 1'b0;
         ackHold           <= 1'b0;
      end else begin
         if (faultSet) telegramLossFault <= 1'b1;
         else if (faultAck) telegramLossFault <= 1'b0;
         if (frameOk) ackHold <= 1'b0;
         else if (faultAck) ackHold <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         telegramLossAlarm <= 1'b0;
         quickStopReaction <= 1'b0;
      end else begin
         telegramLossAlarm <= telegramLossFlag;
         quickStopReaction <= telegramLossFault && quickStopEnable;
      end
   end

   logic [15:0] flashCnt;
   logic        flashPhase;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flashCnt   <= 16'h0000;
         flashPhase <= 1'b0;
      end else if (tick) begin
         flashCnt <= flashCnt + 16'h0001;
         if (flashCnt + 16'h0001 >= `FLASH_HALF_MS) begin
            flashCnt   <= 16'h0000;
            flashPhase <= !flashPhase;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !exchanged) begin
         statusLedGreen <= 1'b0;
         statusLedRed   <= 1'b0;
      end else if (telegramLossFlag) begin
         statusLedGreen <= 1'b0;
         statusLedRed   <= 1'b1;
      end else begin
         statusLedGreen <= lastFull ? 1'b1 : flashPhase;
         statusLedRed   <= 1'b0;
      end
   end

   // Send side: a word generator feeds a two-entry buffer so master stalls lose nothing.
   send_state_type    sendState;
   logic [3:0]        sendIdx;
   logic [3:0]        sendLen;
   logic              headValid;
   logic              tailValid;
   telegram_word_type tail;
   telegram_word_type genWord;
   logic              push;
   logic              pop;
   logic [15:0]       statusWord;

   // Ready for master control only while the bus runs and no loss is pending.
   always_comb begin
      statusWord = actualValues.statusBits;
      statusWord[`READY_BIT] = exchanged && !telegramLossFlag && !telegramLossFault;
   end

   always_comb begin
      genWord.index = sendIdx;
      genWord.last  = sendIdx + 4'h1 == sendLen;
      case (txMap[sendIdx])
         SRC_STATUS:     genWord.data = statusWord;
         SRC_SPEED:      genWord.data = actualValues.speedActualA;
         SRC_SPEED_FILT: genWord.data = actualValues.speedActualFiltered;
         SRC_CURRENT:    genWord.data = actualValues.armatureCurrentFiltered;
         SRC_TORQUE:     genWord.data = actualValues.torqueActualFiltered;
         SRC_POWER:      genWord.data = actualValues.powerActualFiltered;
         SRC_PROCESS:    genWord.data = actualValues.processSignalWord;
         SRC_ALARM:      genWord.data = actualValues.alarmCode;
         SRC_FAULT:      genWord.data = actualValues.faultCode;
         default:        genWord.data = 16'h0000;
      endcase
   end

   assign push = sendState == SEND_BUSY && !tailValid;
   assign pop  = headValid && txReady;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sendState <= SEND_IDLE;
         sendIdx   <= 4'h0;
         sendLen   <= 4'h0;
      end else begin
         case (sendState)
            SEND_IDLE: begin
               if (txRequest && txLen(telegramSelect) != 4'h0) begin
                  sendLen   <= txLen(telegramSelect);
                  sendIdx   <= 4'h0;
                  sendState <= SEND_BUSY;
               end
            end
            SEND_BUSY: begin
               if (push) begin
                  sendIdx <= sendIdx + 4'h1;
                  if (genWord.last) sendState <= SEND_IDLE;
               end
            end
            default: sendState <= SEND_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         headValid <= 1'b0;
         tailValid <= 1'b0;
         txWord    <= '0;
         tail      <= '0;
      end else if (pop && tailValid) begin
         txWord    <= tail;
         tailValid <= 1'b0;
      end else if (pop && push) begin
         txWord <= genWord;
      end else if (pop) begin
         headValid <= 1'b0;
      end else if (push && !headValid) begin
         txWord    <= genWord;
         headValid <= 1'b1;
      end else if (push) begin
         tail      <= genWord;
         tailValid <= 1'b1;
      end
   end

   assign txValid = headValid;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence lossRaised;
      !telegramLossFlag ##1 telegramLossFlag;
   endsequence

   chk_led_dark: assert property (!exchanged ##1 !exchanged |-> !statusLedGreen && !statusLedRed)
      else $error("indicator lit before exchange");
   chk_led_steady: assert property (exchanged && !telegramLossFlag && lastFull |=> statusLedGreen && !statusLedRed)
      else $error("indicator not steady green");
   chk_led_flash: assert property (exchanged && !telegramLossFlag && !lastFull |=> statusLedGreen == $past(flashPhase))
      else $error("indicator not following flash phase");
   chk_led_red: assert property (telegramLossFlag |=> statusLedRed && !statusLedGreen)
      else $error("indicator not red after loss");
   chk_loss_cause: assert property (lossRaised |-> $past(tick) && monCnt >= lossMonitorTime)
      else $error("loss flag without timeout");
   chk_alarm_follow: assert property (telegramLossFlag |=> telegramLossAlarm)
      else $error("alarm does not follow flag");
   chk_quick_stop: assert property (telegramLossFault |=> quickStopReaction == $past(quickStopEnable))
      else $error("quick stop reaction wrong");
   chk_fault_ack: assert property (faultAck && !faultSet |=> !telegramLossFault)
      else $error("acknowledge did not clear fault");
   chk_timer_restart: assert property (frameOk |=> monCnt == 16'h0000 && delayCnt == 16'h0000 && !telegramLossFlag)
      else $error("timers not restarted");
   chk_map_lock: assert property (cfgWrite && !cfgRxSide && !loadMap && cfgIndex < `LEN_FREE && txLock[cfgIndex]
      |=> txMap[$past(cfgIndex)] == $past(txMap[cfgIndex]))
      else $error("locked mapping was changed");
   chk_buffer_hold: assert property (txValid && !txReady |=> txValid && $stable(txWord))
      else $error("send word dropped under stall");

endmodule

// ---- bench/fieldbus_master_model.sv ----
// Behavioural fieldbus master: sends receive telegrams and drains send telegrams.
// Assumes one ref_clk; the bench calls its tasks and reads the got queue.
`timescale 1ns/1ps
module fieldbus_master_model
   import fieldbus_pkg::*;
(
   input  wire logic        ref_clk,
   output telegram_word_type rxWord,
   output logic              rxValid,
   output logic              txRequest,
   output logic              txReady,
   input  wire logic              txValid,
   input  wire telegram_word_type txWord
);
   logic [2:0]        stallCnt = 3'h0;
   telegram_word_type got[$];

   initial begin
      rxValid = 1'b0;
      rxWord = '0;
      txRequest = 1'b0;
   end

   // Ready runs four cycles low, four high, so the buffer fills and must hold words.
   always @(posedge ref_clk) begin
      stallCnt <= stallCnt + 3'h1;
      txReady <= stallCnt[2];
      if (txValid === 1'b1 && txReady) got.push_back(txWord);
   end

   // Word 0 always carries the main control word; the ready bit is never assumed.
   task automatic send_tel(input int n, input logic [15:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         rxValid <= 1'b1;
         rxWord <= '{index: 4'(i), last: (i == n - 1), data: base + 16'(i)};
      end
      @(posedge ref_clk);
      rxValid <= 1'b0;
      rxWord <= ~rxWord;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic fetch(input int n);
      got.delete();
      @(posedge ref_clk);
      txRequest <= 1'b1;
      @(posedge ref_clk);
      txRequest <= 1'b0;
      for (int k = 0; k < 400 && got.size() < n; k++) @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
   endtask
endmodule

// ---- bench/tb_fieldbus_process_data_monitor.sv ----
// Self-checking bench for the process-data monitor against a queue-based model.
// Assumes the prescaler is shortened to four clocks per tick.
`timescale 1ns/1ps
module tb_fieldbus_process_data_monitor;
   import fieldbus_pkg::*;
   localparam int TICK = 4;
   logic ref_clk, sys_rst, rxValid, selWrite, selExtended, cfgWrite, cfgRxSide;
   logic quickStopEnable, faultAck, txRequest, txReady, txValid;
   logic              telegramLossFlag, telegramLossAlarm, telegramLossFault;
   logic              quickStopReaction, statusLedGreen, statusLedRed;
   logic [9:0]        selValue, telegramSelect, telegramSelectExtended;
   logic [3:0]        cfgIndex, cfgCode;
   logic [15:0]       lossMonitorTime, lossFaultDelay, controlWordOne, speedSetpointA;
   logic [3:0][15:0]  systemSetpoint;
   telegram_word_type rxWord, txWord;
   actual_values_type actualValues;
   logic [31:0]       seed;
   logic [143:0]      av;
   int                n_errors, n_compared, n;
   int txMap[10] = '{1, 2, 0, 0, 0, 0, 0, 0, 0, 0};
   int txLoad[3][6] = '{'{1, 2, 0, 0, 0, 0}, '{1, 3, 4, 5, 6, 7}, '{1, 3, 4, 5, 8, 9}};
   int lens[4] = '{2, 6, 6, 10};
   logic [9:0] codes[4] = '{10'h001, 10'h014, 10'h160, 10'h3e7};

   fieldbus_process_data_monitor #(.TICK_CYCLES(TICK)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .rxValid(rxValid), .rxWord(rxWord), .actualValues(actualValues), .selWrite(selWrite),
      .selExtended(selExtended), .selValue(selValue), .cfgWrite(cfgWrite), .cfgRxSide(cfgRxSide),
      .cfgIndex(cfgIndex), .cfgCode(cfgCode), .lossMonitorTime(lossMonitorTime), .lossFaultDelay(lossFaultDelay),
      .quickStopEnable(quickStopEnable), .faultAck(faultAck), .txRequest(txRequest), .txReady(txReady),
      .txValid(txValid), .txWord(txWord), .controlWordOne(controlWordOne), .speedSetpointA(speedSetpointA),
      .systemSetpoint(systemSetpoint), .telegramSelect(telegramSelect),
      .telegramSelectExtended(telegramSelectExtended), .telegramLossFlag(telegramLossFlag),
      .telegramLossAlarm(telegramLossAlarm), .telegramLossFault(telegramLossFault),
      .quickStopReaction(quickStopReaction), .statusLedGreen(statusLedGreen), .statusLedRed(statusLedRed));
   fieldbus_master_model i_master (.ref_clk(ref_clk), .rxWord(rxWord), .rxValid(rxValid),
      .txRequest(txRequest), .txReady(txReady), .txValid(txValid), .txWord(txWord));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Status word 1 leaves with its ready bit forced high while exchange is healthy.
   function automatic logic [15:0] src_val(input int s);
      logic [15:0] v[10];
      v = '{16'h0000, actualValues.statusBits, actualValues.speedActualA,
         actualValues.speedActualFiltered, actualValues.armatureCurrentFiltered,
         actualValues.torqueActualFiltered, actualValues.powerActualFiltered,
         actualValues.processSignalWord, actualValues.alarmCode, actualValues.faultCode};
      v[1][9] = 1'b1;
      return (s < 10) ? v[s] : 16'h0000;
   endfunction

   task automatic chk16(input logic [15:0] act, input logic [15:0] exp);
      n_compared++;
      if (act !== exp) begin
         n_errors++;
         $display("[FAIL] %0t word %h expected %h", $time, act, exp);
      end
   endtask

   task automatic chk1(input logic act, input logic exp);
      n_compared++;
      if (act !== exp) begin
         n_errors++;
         $display("[FAIL] %0t bit %b expected %b", $time, act, exp);
      end
   endtask

   task automatic pulse(input int kind, input logic a, input logic [9:0] v, input logic [3:0] c);
      @(posedge ref_clk);
      selWrite <= (kind == 0);
      cfgWrite <= (kind == 1);
      selExtended <= a;
      cfgRxSide <= a;
      selValue <= v;
      cfgIndex <= v[3:0];
      cfgCode <= c;
      @(posedge ref_clk);
      selWrite <= 1'b0;
      cfgWrite <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic wait_val(ref logic s, input logic v, input int lim, output int cnt);
      for (cnt = 0; cnt < lim && s !== v; cnt++) @(posedge ref_clk);
      #1;
   endtask

   task automatic check_tx(input int len);
      i_master.fetch(len);
      chk16(16'(i_master.got.size()), 16'(len));
      foreach (i_master.got[i]) begin
         chk16(i_master.got[i].data, src_val(txMap[i]));
         chk16(16'(i_master.got[i].index), 16'(i));
         chk1(i_master.got[i].last, i == len - 1);
      end
   endtask

   task automatic stop_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge ref_clk);
      n_errors++;
      stop_test();
   end

   initial begin
      {selWrite, selExtended, cfgWrite, cfgRxSide, faultAck} = '0;
      {selValue, cfgIndex, cfgCode, lossMonitorTime, lossFaultDelay} = '0;
      quickStopEnable = 1'b1;
      seed = 32'h1a01;
      for (int k = 0; k < 9; k++) begin
         seed = lfsr(seed);
         av[k*16+:16] = seed[15:0];
      end
      actualValues = av;
      sys_rst = 1'b1;
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk16(16'(telegramSelect), 16'h03e7);
      chk1(statusLedGreen | statusLedRed, 1'b0);
      i_master.send_tel(2, 16'h0001);
      chk16(controlWordOne, 16'h0001);
      chk16(speedSetpointA, 16'h0002);
      chk1(statusLedGreen, 1'b1);
      i_master.send_tel(1, 16'h0400);
      chk1(statusLedGreen, 1'b0);
      // The flash phase runs free from reset, so only a whole lit half-period is timed.
      wait_val(statusLedGreen, 1'b1, 4100, n);
      wait_val(statusLedGreen, 1'b0, 4100, n);
      chk1(n >= 1000 * TICK - 8 && n <= 1000 * TICK + 8, 1'b1);
      for (int c = 0; c < 4; c++) begin
         pulse(0, 1'b0, codes[c], 4'h0);
         for (int i = 0; i < lens[c] && c < 3; i++) txMap[i] = txLoad[c][i];
         if (c == 0) i_master.send_tel(3, 16'h0100);
         if (c == 0) chk16(controlWordOne, 16'h0400);
         if (c == 2) begin
            pulse(1, 1'b0, 10'h000, SRC_SPEED);
            pulse(1, 1'b0, 10'h005, SRC_STATUS);
            txMap[5] = 1;
            i_master.send_tel(6, 16'h0010);
            for (int i = 0; i < 4; i++) chk16(systemSetpoint[i], 16'h0012 + 16'(i));
         end
         check_tx(lens[c]);
      end
      pulse(0, 1'b1, 10'h001, 4'h0);
      chk16(16'(telegramSelectExtended), 16'h0001);
      txMap[1] = 2;
      check_tx(10);
      lossMonitorTime <= 16'h0003;
      lossFaultDelay <= 16'h0002;
      for (int r = 0; r < 2; r++) begin
         quickStopEnable <= (r == 0);
         i_master.send_tel(2, 16'h0401);
         chk1(telegramLossFlag, 1'b0);
         wait_val(telegramLossFlag, 1'b1, 60, n);
         chk1(n >= 2 * TICK - 4 && n <= 4 * TICK, 1'b1);
         @(posedge ref_clk);
         #1;
         chk1(telegramLossAlarm, 1'b1);
         chk1(statusLedRed, 1'b1);
         wait_val(telegramLossFault, 1'b1, 60, n);
         chk1(n >= TICK - 4 && n <= 3 * TICK + 4, 1'b1);
         @(posedge ref_clk);
         #1;
         chk1(quickStopReaction, r == 0);
         @(posedge ref_clk);
         faultAck <= 1'b1;
         // Held for two edges: a tick on the first re-sets the fault, and the set wins.
         repeat (2) @(posedge ref_clk);
         faultAck <= 1'b0;
         repeat (2) @(posedge ref_clk);
         #1;
         chk1(telegramLossFault, 1'b0);
      end
      stop_test();
   end
endmodule
